// [rtl/pirqm_defines.svh]
/*
  constants for the peripheral interrupt merge block: register indices,
  field positions, reset values.
  assumes: included by bare name; byte address = 4 * register index.
*/
`ifndef PIRQM_DEFINES_SVH
`define PIRQM_DEFINES_SVH

// register indices
`define PIRQM_IDX_CLOCK_CONTROL 10'h020
`define PIRQM_IDX_FREQ_TRIM 10'h021
`define PIRQM_IDX_CNT_CTRL 10'h040
`define PIRQM_IDX_CNT1_LO 10'h041
`define PIRQM_IDX_CNT1_HI 10'h042
`define PIRQM_IDX_CNT2_LO 10'h043
`define PIRQM_IDX_CNT2_HI 10'h044
// status and mask sit above the byte-wide map so 45h to ffh stay unused
`define PIRQM_IDX_IRQ_STATUS 10'h100
`define PIRQM_IDX_IRQ_MASK 10'h101

// clock control fields
`define PIRQM_CLK_ECI 0
`define PIRQM_CLK_CIF 1
`define PIRQM_CLK_RUN 3

// counter control fields
`define PIRQM_CC_C2F 0
`define PIRQM_CC_CNT2_IRQ_ENABLE 2
`define PIRQM_CC_EC2 3
`define PIRQM_CC_C1F 4
`define PIRQM_CC_CNT1_IRQ_ENABLE 6
`define PIRQM_CC_EC1 7
`define PIRQM_CC_WMASK 8'hdd

// sticky status bits
`define PIRQM_ST_RTC 0
`define PIRQM_ST_CNT1 1
`define PIRQM_ST_CNT2 2
`define PIRQM_ST_PIN 3

`define PIRQM_RST_BYTE 8'h00
`define PIRQM_RST_CNT 16'h0000
`define PIRQM_CNT_ALL_ONES 16'hffff

`endif

// [rtl/pirqm_pkg.sv]
/*
  types for the peripheral interrupt merge block.
  assumes: constants live in pirqm_defines.svh.
*/
package pirqm_pkg;

  typedef logic [7:0] pirqm_byte_t;
  typedef logic [15:0] pirqm_count_t;
  typedef logic [3:0] pirqm_status_t;

endpackage : pirqm_pkg

// [rtl/pirqm_top.sv]
/*
  peripheral interrupt merge: clock tick and two pulse counters merged onto
  the external interrupt request, with their register file on apb.
  assumes: one 200 MHz clock; rtc_tick is a one-cycle pulse on clk;
  count inputs, ext_irq_pin and power-mode inputs are asynchronous levels.
*/
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "pirqm_defines.svh"

module pirqm_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rtc_tick,
  input wire logic cnt1_clk_pin,
  input wire logic cnt2_clk_pin,
  input wire logic ext_irq_pin,
  input wire logic ext_irq_enable_instr,
  input wire logic irq_in_progress,
  input wire logic idle_mode,
  input wire logic stop_mode,
  output logic ext_irq_req,
  output logic periph_irq_service,
  output logic wake_req,
  output logic osc_run,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  pirqm_pkg::pirqm_byte_t clock_control_r;
  pirqm_pkg::pirqm_byte_t frequency_trim_r;
  pirqm_pkg::pirqm_byte_t counter_control_status_r;
  pirqm_pkg::pirqm_count_t cnt1_r;
  pirqm_pkg::pirqm_count_t cnt2_r;
  pirqm_pkg::pirqm_status_t irq_status_r;
  pirqm_pkg::pirqm_status_t irq_mask_r;
  pirqm_pkg::pirqm_count_t cnt1_nxt;
  pirqm_pkg::pirqm_count_t cnt2_nxt;
  pirqm_pkg::pirqm_byte_t cc_nxt;
  pirqm_pkg::pirqm_byte_t clk_nxt;
  logic [2:0] c1_sync_r;
  logic [2:0] c2_sync_r;
  logic [1:0] pin_sync_r;
  logic [1:0] idle_sync_r;
  logic [1:0] stop_sync_r;
  logic pin_prev_r;
  logic pin_lvl;
  logic c1_fall;
  logic c2_fall;
  logic c1_step;
  logic c2_step;
  logic c1_ovf;
  logic c2_ovf;
  logic rtc_event;
  logic wr_en;
  logic rd_setup;
  logic [9:0] idx;
  logic aligned;
  logic mapped;
  logic wr_clk;
  logic wr_cc;
  logic [7:0] wb;
  logic [7:0] rd_byte;
  logic periph_req;
  logic rtc_run;

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers; the first stage feeds only the second

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      c1_sync_r <= 3'h0;
      c2_sync_r <= 3'h0;
      pin_sync_r <= 2'h0;
      idle_sync_r <= 2'h0;
      stop_sync_r <= 2'h0;
      pin_prev_r <= 1'b0;
    end
    else
    begin
      c1_sync_r <= {c1_sync_r[1:0], cnt1_clk_pin};
      c2_sync_r <= {c2_sync_r[1:0], cnt2_clk_pin};
      pin_sync_r <= {pin_sync_r[0], ext_irq_pin};
      idle_sync_r <= {idle_sync_r[0], idle_mode};
      stop_sync_r <= {stop_sync_r[0], stop_mode};
      pin_prev_r <= pin_sync_r[1];
    end
  end

  assign pin_lvl = pin_sync_r[1];
  // bit 2 is the previous synchronised sample
  assign c1_fall = c1_sync_r[2] & ~c1_sync_r[1];
  assign c2_fall = c2_sync_r[2] & ~c2_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, read data captured in the setup cycle

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  always_comb
  begin
    unique case (idx)
      `PIRQM_IDX_CLOCK_CONTROL, `PIRQM_IDX_FREQ_TRIM,
      `PIRQM_IDX_CNT_CTRL, `PIRQM_IDX_CNT1_LO, `PIRQM_IDX_CNT1_HI,
      `PIRQM_IDX_CNT2_LO, `PIRQM_IDX_CNT2_HI,
      `PIRQM_IDX_IRQ_STATUS, `PIRQM_IDX_IRQ_MASK: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wb = pwdata[7:0];
  assign wr_clk = wr_en & (idx == `PIRQM_IDX_CLOCK_CONTROL);
  assign wr_cc = wr_en & (idx == `PIRQM_IDX_CNT_CTRL);

  always_comb
  begin
    unique case (idx)
      `PIRQM_IDX_CLOCK_CONTROL: rd_byte = clock_control_r;
      `PIRQM_IDX_FREQ_TRIM: rd_byte = frequency_trim_r;
      `PIRQM_IDX_CNT_CTRL: rd_byte = counter_control_status_r;
      `PIRQM_IDX_CNT1_LO: rd_byte = cnt1_r[7:0];
      `PIRQM_IDX_CNT1_HI: rd_byte = cnt1_r[15:8];
      `PIRQM_IDX_CNT2_LO: rd_byte = cnt2_r[7:0];
      `PIRQM_IDX_CNT2_HI: rd_byte = cnt2_r[15:8];
      `PIRQM_IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status_r};
      `PIRQM_IDX_IRQ_MASK: rd_byte = {4'h0, irq_mask_r};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rd_setup)
    begin
      // unmapped or misaligned reads return zero with an error
      prdata <= {24'h00_0000, (aligned ? rd_byte : 8'h00)};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock control and frequency trim

  assign rtc_run = clock_control_r[`PIRQM_CLK_RUN];
  // in every power mode the tick only counts while the run bit is set
  assign rtc_event = rtc_tick & rtc_run;

  always_comb
  begin
    clk_nxt = clock_control_r;
    if (wr_clk)
    begin
      clk_nxt = wb;
    end
    if (rtc_event)
    begin
      // set beats a software clear in the same cycle
      clk_nxt[`PIRQM_CLK_CIF] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clock_control_r <= `PIRQM_RST_BYTE;
      frequency_trim_r <= `PIRQM_RST_BYTE;
    end
    else
    begin
      clock_control_r <= clk_nxt;
      if (wr_en && idx == `PIRQM_IDX_FREQ_TRIM)
      begin
        frequency_trim_r <= wb;
      end
    end
  end

  // oscillator held off in stop mode unless something needs it
  assign osc_run = ~stop_sync_r[1] | rtc_run
    | counter_control_status_r[`PIRQM_CC_EC1]
    | counter_control_status_r[`PIRQM_CC_EC2];

  ////////////////////////////////////////////////////////////////////////////
  // pulse counters, running in every power mode when enabled

  assign c1_step = c1_fall & counter_control_status_r[`PIRQM_CC_EC1];
  assign c2_step = c2_fall & counter_control_status_r[`PIRQM_CC_EC2];
  assign c1_ovf = c1_step & (cnt1_r == `PIRQM_CNT_ALL_ONES)
    & counter_control_status_r[`PIRQM_CC_CNT1_IRQ_ENABLE];
  assign c2_ovf = c2_step & (cnt2_r == `PIRQM_CNT_ALL_ONES)
    & counter_control_status_r[`PIRQM_CC_CNT2_IRQ_ENABLE];

  always_comb
  begin
    cnt1_nxt = cnt1_r;
    cnt2_nxt = cnt2_r;
    // a byte write takes priority; a count edge in that cycle is lost
    if (wr_en && idx == `PIRQM_IDX_CNT1_LO)
    begin
      cnt1_nxt[7:0] = wb;
    end
    else if (wr_en && idx == `PIRQM_IDX_CNT1_HI)
    begin
      cnt1_nxt[15:8] = wb;
    end
    else if (c1_step)
    begin
      cnt1_nxt = cnt1_r + 16'h0001;
    end
    if (wr_en && idx == `PIRQM_IDX_CNT2_LO)
    begin
      cnt2_nxt[7:0] = wb;
    end
    else if (wr_en && idx == `PIRQM_IDX_CNT2_HI)
    begin
      cnt2_nxt[15:8] = wb;
    end
    else if (c2_step)
    begin
      cnt2_nxt = cnt2_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt1_r <= `PIRQM_RST_CNT;
      cnt2_r <= `PIRQM_RST_CNT;
    end
    else
    begin
      cnt1_r <= cnt1_nxt;
      cnt2_r <= cnt2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter control and status

  always_comb
  begin
    cc_nxt = counter_control_status_r;
    if (wr_cc)
    begin
      cc_nxt = wb & `PIRQM_CC_WMASK;
    end
    // overflow wins over a clear written in the same cycle
    if (c1_ovf)
    begin
      cc_nxt[`PIRQM_CC_C1F] = 1'b1;
    end
    if (c2_ovf)
    begin
      cc_nxt[`PIRQM_CC_C2F] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      counter_control_status_r <= `PIRQM_RST_BYTE;
    end
    else
    begin
      counter_control_status_r <= cc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // merge onto the external interrupt request

  // the pin enters the final or and the service gate; of the flags it sets only status bit 3
  assign periph_req =
    (clock_control_r[`PIRQM_CLK_CIF] & clock_control_r[`PIRQM_CLK_ECI])
    | (counter_control_status_r[`PIRQM_CC_C1F]
       & counter_control_status_r[`PIRQM_CC_CNT1_IRQ_ENABLE])
    | (counter_control_status_r[`PIRQM_CC_C2F]
       & counter_control_status_r[`PIRQM_CC_CNT2_IRQ_ENABLE]);
  assign ext_irq_req = periph_req | pin_lvl;
  // needs the core's enable; a pending pin request goes first
  assign periph_irq_service = periph_req & ext_irq_enable_instr
    & ~irq_in_progress & ~pin_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // wake-up from idle and stop

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wake_req <= 1'b0;
    end
    else
    begin
      // one-cycle pulse on a clock tick or counter overflow while asleep, not on the pin
      wake_req <= (idle_sync_r[1] | stop_sync_r[1])
        & (rtc_event | c1_ovf | c2_ovf);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky event status, write one to clear, with mask

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_status_r <= 4'h0;
      irq_mask_r <= 4'h0;
    end
    else
    begin
      // new events win over a clear in the same cycle
      irq_status_r <= (irq_status_r
        & ~((wr_en && idx == `PIRQM_IDX_IRQ_STATUS) ? wb[3:0] : 4'h0))
        | {pin_lvl & ~pin_prev_r, c2_ovf, c1_ovf, rtc_event};
      if (wr_en && idx == `PIRQM_IDX_IRQ_MASK)
      begin
        irq_mask_r <= wb[3:0];
      end
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

endmodule : pirqm_top

// [tb/pirqm_chk.sv]
/* port assertions for the merge block.
   assumes: bound to pirqm_top; one clock, async low reset. */
`timescale 1ns/1ps
module pirqm_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic ext_irq_pin,
  input wire logic ext_irq_enable_instr,
  input wire logic irq_in_progress,
  input wire logic stop_mode,
  input wire logic ext_irq_req,
  input wire logic periph_irq_service,
  input wire logic wake_req,
  input wire logic osc_run
);
  logic acc;
  assign acc = psel && penable;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  // three samples: the pin crosses two sync stages first
  sequence s_pin_held;
    ext_irq_pin [*3];
  endsequence
  chk_ctrl_zero: assert property (acc && !pwrite && paddr == 12'h100
    |-> prdata[5] == 1'b0 && prdata[1] == 1'b0)
    else $error("counter control spare bit reads one");
  chk_err_low: assert property (acc && (paddr < 12'h080 ||
    (paddr >= 12'h088 && paddr < 12'h100)) |-> pslverr)
    else $error("unused low address accepted");
  chk_err_high: assert property (acc && paddr >= 12'h114
    && paddr < 12'h400 |-> pslverr)
    else $error("unused high address accepted");
  chk_ok_mapped: assert property (acc && paddr inside {12'h080,
    12'h084, 12'h100, 12'h104, 12'h108, 12'h10c, 12'h110, 12'h400,
    12'h404} |-> !pslverr)
    else $error("mapped register refused");
  chk_pin_merge: assert property (s_pin_held |-> ext_irq_req)
    else $error("pin not on request path");
  chk_pin_blocks: assert property (s_pin_held |-> !periph_irq_service)
    else $error("peripheral served while pin pending");
  chk_serve_gate: assert property (periph_irq_service |->
    ext_irq_enable_instr && !irq_in_progress && ext_irq_req)
    else $error("peripheral served without its conditions");
  chk_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  chk_osc_awake: assert property (!stop_mode [*4] |-> osc_run)
    else $error("oscillator off outside stop");
endmodule : pirqm_chk

// [tb/pirqm_core.sv]
/* core-side model: interrupt enable and routine entry.
   assumes: same clock as the merge block. */
`timescale 1ns/1ps
module pirqm_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ext_irq_req,
  input wire logic en_cmd,
  input wire logic take_cmd,
  input wire logic ret_cmd,
  output logic ext_irq_enable_instr,
  output logic irq_in_progress
);
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      ext_irq_enable_instr <= 1'b0;
    else
      ext_irq_enable_instr <= en_cmd;
  // take_cmd low models a slow core that has not vectored yet
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      irq_in_progress <= 1'b0;
    else if (ret_cmd)
      irq_in_progress <= 1'b0;
    else if (take_cmd && ext_irq_req && ext_irq_enable_instr)
      irq_in_progress <= 1'b1;
endmodule : pirqm_core

// [tb/test_peripheral_irq_merge_regs.sv]
/* bench for the merge block: register rows, then reset, refusal,
   counter, clock, pin, status and core cases.
   assumes: zero-wait apb slave; core modelled by pirqm_core. */
`timescale 1ns/1ps
module test_peripheral_irq_merge_regs;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] d;
    logic [7:0] q;
    logic r;
  } pirqm_row_t;
  pirqm_row_t rows [12];
  logic [11:0] regs [7];
  logic [11:0] bad [4];
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, rtc_tick;
  logic c1, c2, pin, idle, stop, en_cmd, take_cmd, ret_cmd, eie, iip;
  logic req, svc, wake, osc, irq, err_v;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  int num_errors, check_count, wakes, w0;
  pirqm_top dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtc_tick(rtc_tick),
    .cnt1_clk_pin(c1), .cnt2_clk_pin(c2), .ext_irq_pin(pin),
    .ext_irq_enable_instr(eie), .irq_in_progress(iip), .idle_mode(idle),
    .stop_mode(stop), .ext_irq_req(req), .periph_irq_service(svc),
    .wake_req(wake), .osc_run(osc), .irq(irq));
  pirqm_core core (.clk(clk), .rstn(rstn), .ext_irq_req(req),
    .en_cmd(en_cmd), .take_cmd(take_cmd), .ret_cmd(ret_cmd),
    .ext_irq_enable_instr(eie), .irq_in_progress(iip));
  ////////////////////////////////////////
  task automatic conclude();
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr} <= {1'b1, 1'b0, w, a};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready === 1'b1)
    begin
      rd_v = prdata;
      err_v = pslverr;
      {psel, penable} <= 2'b00;
    end
    else
    begin
      // a hung slave counts as a mismatch and ends the run
      num_errors++;
      conclude();
    end
  endtask : apb
  // falling pin edge counts; held wide so the sync stages see it
  task automatic pulse(input int k);
    if (k == 1)
      c2 <= 1'b1;
    else
      c1 <= 1'b1;
    repeat (4) @(posedge clk);
    {c1, c2} <= 2'b00;
    repeat (8) @(posedge clk);
  endtask : pulse
  always @(posedge clk)
    if (wake === 1'b1)
      wakes <= wakes + 1;
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////
  initial
  begin
    {rstn, psel, penable, pwrite, rtc_tick, c1, c2, pin} <= '0;
    {idle, stop, en_cmd, take_cmd, ret_cmd, paddr, pwdata} <= '0;
    rows = '{'{12'h080, 8'h03, 8'h03, 1'b1}, '{12'h080, 8'h02, 8'h02, 1'b0},
      '{12'h080, 8'h01, 8'h01, 1'b0}, '{12'h100, 8'h50, 8'h50, 1'b1},
      '{12'h100, 8'h10, 8'h10, 1'b0}, '{12'h100, 8'h40, 8'h40, 1'b0},
      '{12'h100, 8'h05, 8'h05, 1'b1}, '{12'h100, 8'h01, 8'h01, 1'b0},
      '{12'h100, 8'h22, 8'h00, 1'b0}, '{12'h084, 8'ha5, 8'ha5, 1'b0},
      '{12'h104, 8'h3c, 8'h3c, 1'b0}, '{12'h110, 8'hc3, 8'hc3, 1'b0}};
    regs = '{12'h080, 12'h084, 12'h100, 12'h104, 12'h108, 12'h10c, 12'h110};
    bad = '{12'h000, 12'h08c, 12'h114, 12'h081};
    repeat (20) @(posedge clk);
    {rstn, en_cmd} <= 2'b11;
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 8'h00);
      chk(rd_v, {24'h0, rows[i].q});
      chk({31'h0, req}, {31'h0, rows[i].r});
      chk({31'h0, svc}, {31'h0, rows[i].r});
    end
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    foreach (bad[i])
    begin
      apb(1'b1, bad[i], 8'hff);
      chk({31'h0, err_v}, 32'h1);
      apb(1'b0, bad[i], 8'h00);
      chk(rd_v, 32'h0);
    end
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 8'h00);
      chk(rd_v, 32'h0);
    end
    stop <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      w0 = wakes;
      apb(1'b1, 12'h104 + 12'(8 * k), 8'hff);
      apb(1'b1, 12'h108 + 12'(8 * k), 8'hff);
      apb(1'b1, 12'h100, k ? 8'h0c : 8'hc0);
      pulse(k);
      apb(1'b0, 12'h100, 8'h00);
      chk(rd_v, k ? 32'h0d : 32'hd0);
      chk(wakes - w0, 32'h1);
      apb(1'b0, 12'h104 + 12'(8 * k), 8'h00);
      chk(rd_v, 32'h0);
      repeat (8) @(posedge clk);
      apb(1'b0, 12'h100, 8'h00);
      chk(rd_v, k ? 32'h0d : 32'hd0);
      apb(1'b1, 12'h100, k ? 8'h0c : 8'hc0);
      apb(1'b0, 12'h100, 8'h00);
      chk(rd_v, k ? 32'h0c : 32'hc0);
    end
    apb(1'b1, 12'h100, 8'h80);
    apb(1'b1, 12'h104, 8'hff);
    apb(1'b1, 12'h108, 8'hff);
    pulse(0);
    apb(1'b0, 12'h100, 8'h00);
    chk(rd_v, 32'h80);
    apb(1'b1, 12'h100, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    chk({31'h0, osc}, 32'h0);
    apb(1'b1, 12'h080, 8'h08);
    apb(1'b0, 12'h080, 8'h00);
    chk({31'h0, osc}, 32'h1);
    {stop, idle} <= 2'b01;
    w0 = wakes;
    repeat (4) @(posedge clk);
    rtc_tick <= 1'b1;
    @(posedge clk);
    rtc_tick <= 1'b0;
    apb(1'b0, 12'h080, 8'h00);
    chk(rd_v, 32'h0a);
    chk(wakes - w0, 32'h1);
    // two overflows and one tick since the mid-run reset, never cleared
    apb(1'b0, 12'h400, 8'h00);
    chk(rd_v, 32'h07);
    idle <= 1'b0;
    apb(1'b1, 12'h080, 8'h08);
    apb(1'b1, 12'h400, 8'h0f);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({31'h0, req}, 32'h1);
    chk({31'h0, svc}, 32'h0);
    apb(1'b0, 12'h080, 8'h00);
    chk(rd_v, 32'h08);
    apb(1'b0, 12'h100, 8'h00);
    chk(rd_v, 32'h0);
    apb(1'b0, 12'h400, 8'h00);
    chk(rd_v, 32'h08);
    apb(1'b1, 12'h404, 8'h08);
    apb(1'b0, 12'h404, 8'h00);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, 12'h404, 8'h00);
    apb(1'b0, 12'h404, 8'h00);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, 12'h404, 8'h08);
    apb(1'b1, 12'h400, 8'h08);
    apb(1'b0, 12'h400, 8'h00);
    chk(rd_v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    pin <= 1'b0;
    apb(1'b1, 12'h100, 8'h50);
    apb(1'b0, 12'h100, 8'h00);
    chk({31'h0, svc}, 32'h1);
    take_cmd <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, svc}, 32'h0);
    @(posedge clk);
    {take_cmd, ret_cmd} <= 2'b01;
    repeat (2) @(posedge clk);
    {ret_cmd, en_cmd} <= 2'b00;
    #1;
    chk({31'h0, svc}, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, svc}, 32'h0);
    chk({31'h0, req}, 32'h1);
    conclude();
  end
endmodule : test_peripheral_irq_merge_regs
bind pirqm_top pirqm_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
  .ext_irq_enable_instr(ext_irq_enable_instr),
  .irq_in_progress(irq_in_progress), .stop_mode(stop_mode),
  .ext_irq_req(ext_irq_req), .periph_irq_service(periph_irq_service),
  .wake_req(wake_req), .osc_run(osc_run));
